// File: logic/mit_map.svh
// register map, field positions and timing counts for the port/timer block
// assumes inclusion by the package and the top module only
`ifndef MIT_MAP_SVH
`define MIT_MAP_SVH
`define MIT_REG_PA_OUT      2'h0
`define MIT_REG_PA_DIR      2'h1
`define MIT_REG_PB_OUT      2'h2
`define MIT_REG_PB_DIR      2'h3
`define MIT_BIT_SEL_TIMER   2
`define MIT_BIT_IRQ_EN      3
`define MIT_PORT_RESET      8'h00
`define MIT_DIV1_LAST       10'h000
`define MIT_DIV8_LAST       10'h007
`define MIT_DIV64_LAST      10'h03F
`define MIT_DIV1024_LAST    10'h3FF
`define MIT_POST_IRQ_FLOOR  8'h01
`endif

// File: logic/mit_pkg.sv
// types shared by the port/timer block
// assumes the map header sits beside it
`include "mit_map.svh"
package mit_pkg;
    typedef enum logic [1:0] {
        MIT_DIV1    = 2'h0,
        MIT_DIV8    = 2'h1,
        MIT_DIV64   = 2'h2,
        MIT_DIV1024 = 2'h3
    } mit_rate_t;
    typedef struct packed {
        logic [7:0] dir;
        logic [7:0] out;
    } mit_port_t;
    typedef enum logic [1:0] {
        MIT_COUNTING = 2'b01,
        MIT_EXPIRED  = 2'b10
    } mit_state_t;
endpackage

// File: logic/mit_io_timer.sv
// two bidirectional ports and the interval timer of a memory/io/timer chip
// assumes a bus access lasts one sys_clk cycle, qualified by ioSelect
`timescale 1ns/1ps
`include "mit_map.svh"

//------------------------------------------------------------
// core module
//------------------------------------------------------------
module mit_io_timer
    import mit_pkg::*;
#(
    parameter bit SHARED_AS_SELECTS = 1'b0,
    parameter bit IRQ_PULLUP        = 1'b1
)(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire logic       ioSelect,
    input  wire logic       readNotWrite,
    input  wire logic [3:0] addressLines,
    input  wire logic [7:0] dataLinesIn,
    output logic      [7:0] dataLinesOut,
    output logic            dataLinesOe,
    input  wire logic [7:0] portALinesIn,
    output logic      [7:0] portALinesOut,
    output logic      [7:0] portALinesOe,
    input  wire logic [7:0] portBLinesIn,
    output logic      [7:0] portBLinesOut,
    output logic      [7:0] portBLinesOe,
    output logic            irqFlag
);
    //------------------------------------------------------------
    // pin input synchronisers
    //------------------------------------------------------------
    logic [15:0] pinS1_q, pinS2_q, pinS3_q, pinLevel_q;
    logic [15:0] pinLevel_d;
    // a change counts once stages two and three agree
    always_comb
    begin
        for (int i = 0; i < 16; i++)
        begin
            pinLevel_d[i] = (pinS2_q[i] == pinS3_q[i]) ? pinS2_q[i] : pinLevel_q[i];
        end
    end
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            pinS1_q    <= 16'h0000;
            pinS2_q    <= 16'h0000;
            pinS3_q    <= 16'h0000;
            pinLevel_q <= 16'h0000;
        end
        else
        begin
            pinS1_q    <= {portBLinesIn, portALinesIn};
            pinS2_q    <= pinS1_q;
            pinS3_q    <= pinS2_q;
            pinLevel_q <= pinLevel_d;
        end
    end

    //------------------------------------------------------------
    // access decode
    //------------------------------------------------------------
    logic isTimer, wrAcc, rdAcc, timerAcc;
    // gating by ioSelect keeps stray cycles from touching state
    assign isTimer  = addressLines[`MIT_BIT_SEL_TIMER];
    assign wrAcc    = ioSelect && !readNotWrite;
    assign rdAcc    = ioSelect && readNotWrite;
    // ioSelect arrives already decoded from the upper address lines; rom and ram selects stay outside
    assign timerAcc = ioSelect && isTimer;

    //------------------------------------------------------------
    // port registers
    //------------------------------------------------------------
    mit_port_t portA_q, portA_d, portB_q, portB_d;
    always_comb
    begin
        portA_d = portA_q;
        portB_d = portB_q;
        // only writes change them; reads leave contents alone
        if (wrAcc && !isTimer)
        begin
            case (addressLines[1:0])
                `MIT_REG_PA_OUT: portA_d.out = dataLinesIn;
                `MIT_REG_PA_DIR: portA_d.dir = dataLinesIn;
                `MIT_REG_PB_OUT: portB_d.out = dataLinesIn;
                `MIT_REG_PB_DIR: portB_d.dir = dataLinesIn;
                default:         portA_d = portA_q;
            endcase
        end
    end
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            portA_q <= '{dir: `MIT_PORT_RESET, out: `MIT_PORT_RESET};
            portB_q <= '{dir: `MIT_PORT_RESET, out: `MIT_PORT_RESET};
        end
        else
        begin
            portA_q <= portA_d;
            portB_q <= portB_d;
        end
    end

    //------------------------------------------------------------
    // interval timer
    //------------------------------------------------------------
    mit_state_t state_q, state_d;
    logic [7:0] count_q, count_d;
    logic [9:0] pre_q, pre_d, preLast_q, preLast_d;
    logic       flag_q, flag_d, irqEn_q, irqEn_d;
    logic       tick;
    assign tick = (pre_q == preLast_q);
    always_comb
    begin
        state_d   = state_q;
        count_d   = count_q;
        pre_d     = tick ? 10'h000 : pre_q + 10'h001;
        preLast_d = preLast_q;
        flag_d    = flag_q;
        irqEn_d   = irqEn_q;
        case (state_q)
            MIT_COUNTING:
            begin
                if (tick)
                begin
                    count_d = count_q - 8'h01;
                    if (count_q == 8'h00)
                    begin
                        flag_d  = 1'b1;
                        state_d = MIT_EXPIRED;
                    end
                end
            end
            MIT_EXPIRED:
            begin
                // stops at minus 255 so elapsed time stays readable
                if (count_q != `MIT_POST_IRQ_FLOOR)
                    count_d = count_q - 8'h01;
            end
            default: state_d = MIT_COUNTING;
        endcase
        if (timerAcc)
        begin
            irqEn_d = addressLines[`MIT_BIT_IRQ_EN];
            // clear only a flag already standing; a setting event wins on a read, but a timer write clears the flag regardless
            if (flag_q)
                flag_d = 1'b0;
        end
        if (timerAcc && wrAcc)
        begin
            count_d = dataLinesIn;
            state_d = MIT_COUNTING;
            pre_d   = 10'h000;
            flag_d  = 1'b0;
            case (mit_rate_t'(addressLines[1:0]))
                MIT_DIV1:    preLast_d = `MIT_DIV1_LAST;
                MIT_DIV8:    preLast_d = `MIT_DIV8_LAST;
                MIT_DIV64:   preLast_d = `MIT_DIV64_LAST;
                MIT_DIV1024: preLast_d = `MIT_DIV1024_LAST;
                default:     preLast_d = `MIT_DIV1_LAST;
            endcase
        end
    end
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            state_q   <= MIT_COUNTING;
            count_q   <= 8'h00;
            pre_q     <= 10'h000;
            preLast_q <= `MIT_DIV1_LAST;
            flag_q    <= 1'b0;
            irqEn_q   <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            count_q   <= count_d;
            pre_q     <= pre_d;
            preLast_q <= preLast_d;
            flag_q    <= flag_d;
            irqEn_q   <= irqEn_d;
        end
    end

    //------------------------------------------------------------
    // read mux and registered outputs
    //------------------------------------------------------------
    logic [7:0] rdData, pbDir, pbOut, pbOe;
    logic       irqLow;
    always_comb
    begin
        rdData = 8'h00;
        if (isTimer)
            rdData = addressLines[0] ? {7'h00, flag_q} : count_q;
        else
        begin
            // input lines show the pin, output lines the stored bit
            case (addressLines[1:0])
                `MIT_REG_PA_OUT: rdData = (portA_q.dir & portA_q.out) |
                                          (~portA_q.dir & pinLevel_q[7:0]);
                `MIT_REG_PA_DIR: rdData = portA_q.dir;
                `MIT_REG_PB_OUT: rdData = (portB_q.dir & portB_q.out) |
                                          (~portB_q.dir & pinLevel_q[15:8]);
                `MIT_REG_PB_DIR: rdData = portB_q.dir;
                default:         rdData = 8'h00;
            endcase
        end
        irqLow = irqEn_q && flag_q;
        // shared select lines never drive when built as selects
        pbDir = portB_q.dir & (SHARED_AS_SELECTS ? 8'h9F : 8'hFF);
        pbOut = portB_q.out;
        pbOe  = pbDir;
        if (irqLow)
        begin
            pbOut[7] = 1'b0;
            pbOe[7]  = 1'b1;
        end
        else if (!pbDir[7] && irqEn_q && IRQ_PULLUP)
        begin
            pbOut[7] = 1'b1;
            pbOe[7]  = 1'b1;
        end
    end
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            dataLinesOut  <= 8'h00;
            dataLinesOe   <= 1'b0;
            portALinesOut <= 8'h00;
            portALinesOe  <= 8'h00;
            portBLinesOut <= 8'h00;
            portBLinesOe  <= 8'h00;
            irqFlag       <= 1'b0;
        end
        else
        begin
            dataLinesOut  <= rdData;
            dataLinesOe   <= rdAcc;
            portALinesOut <= portA_q.out;
            portALinesOe  <= portA_q.dir;
            portBLinesOut <= pbOut;
            portBLinesOe  <= pbOe;
            irqFlag       <= flag_q;
        end
    end

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    a_bus_drive_read: assert property (@(posedge sys_clk) disable iff (reset)
        dataLinesOe == $past(rdAcc)) else $error("data bus drive not tied to read");
    a_port_read_only: assert property (@(posedge sys_clk) disable iff (reset)
        (rdAcc && !isTimer) |=> (portA_q == $past(portA_q) && portB_q == $past(portB_q)))
        else $error("port register changed on read");
    a_zero_sets_flag: assert property (@(posedge sys_clk) disable iff (reset)
        (state_q == MIT_COUNTING && tick && count_q == 8'h00 && !timerAcc)
        |=> (flag_q && count_q == 8'hFF)) else $error("flag not set after zero");
    a_post_decrement: assert property (@(posedge sys_clk) disable iff (reset)
        (state_q == MIT_EXPIRED && !timerAcc && count_q != 8'h01)
        |=> count_q == $past(count_q) - 8'h01) else $error("post-flag decrement wrong");
    a_irq_enable_bit: assert property (@(posedge sys_clk) disable iff (reset)
        timerAcc |=> irqEn_q == $past(addressLines[3])) else $error("irq enable not latched");
    a_irq_pin_low: assert property (@(posedge sys_clk) disable iff (reset)
        (irqEn_q && flag_q) |=> (portBLinesOe[7] && !portBLinesOut[7]))
        else $error("irq line not low");
    a_flag_clear: assert property (@(posedge sys_clk) disable iff (reset)
        (timerAcc && flag_q) |=> !flag_q) else $error("flag not cleared by access");
    a_write_loads: assert property (@(posedge sys_clk) disable iff (reset)
        (timerAcc && wrAcc) |=> (count_q == $past(dataLinesIn) && pre_q == 10'h000))
        else $error("timer write did not load");
endmodule

// File: tb/mit_cpu_model.sv
// processor-side bus model for the port/timer block
// assumes its tasks are called from the bench's main sequence
`timescale 1ns/1ps
module mit_cpu_model
    import mit_pkg::*;
(
    input  wire logic       sys_clk,
    output logic            ioSelect,
    output logic            readNotWrite,
    output logic      [3:0] addressLines,
    output logic      [7:0] dataLinesIn,
    input  wire logic [7:0] dataLinesOut,
    input  wire logic       dataLinesOe
);
    //--------------------------------------------
    // bus cycles, one access edge each
    //--------------------------------------------
    // idle bus: nothing selected, read level
    initial
    begin
        ioSelect     = 1'b0;
        readNotWrite = 1'b1;
        addressLines = 4'h0;
        dataLinesIn  = 8'h00;
    end
    // write: low read/write line while selected; data inverted once released
    task automatic busWrite(input logic [3:0] addr, input logic [7:0] data);
        @(negedge sys_clk);
        ioSelect     = 1'b1;
        readNotWrite = 1'b0;
        addressLines = addr;
        dataLinesIn  = data;
        @(negedge sys_clk);
        ioSelect     = 1'b0;
        readNotWrite = 1'b1;
        dataLinesIn  = ~data;
    endtask
    // read: answer is registered, so it is taken at the falling edge half a cycle after the access edge
    task automatic busRead(input logic [3:0] addr, output logic [7:0] data, output logic oe);
        @(negedge sys_clk);
        ioSelect     = 1'b1;
        readNotWrite = 1'b1;
        addressLines = addr;
        @(negedge sys_clk);
        ioSelect     = 1'b0;
        data         = dataLinesOut;
        oe           = dataLinesOe;
    endtask
endmodule

// File: tb/mit_io_timer_tb.sv
// self-checking bench for the port/timer block
// assumes mit_cpu_model drives the processor side of the bus
`timescale 1ns/1ps
module mit_io_timer_tb;
    import mit_pkg::*;
    //--------------------------------------------
    // signals, pins and model state
    //--------------------------------------------
    logic       sys_clk, reset, ioSelect, readNotWrite, dataLinesOe, irqFlag, oe;
    logic [3:0] addressLines;
    logic [7:0] dataLinesIn, dataLinesOut, extA, extB, aOut, aOe, bOut, bOe, rd, pinA, pinB;
    int         errCount = 0, checksDone = 0, cyc = 0, t0, c, dv, v1;
    int         dirM[2], outM[2];
    // wire level: the driving side wins, else the outside world
    assign pinA = (aOe & aOut) | (~aOe & extA);
    assign pinB = (bOe & bOut) | (~bOe & extB);
    mit_io_timer DUT (.sys_clk(sys_clk), .reset(reset), .ioSelect(ioSelect), .readNotWrite(readNotWrite),
        .addressLines(addressLines), .dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut),
        .dataLinesOe(dataLinesOe), .portALinesIn(pinA), .portALinesOut(aOut), .portALinesOe(aOe),
        .portBLinesIn(pinB), .portBLinesOut(bOut), .portBLinesOe(bOe), .irqFlag(irqFlag));
    mit_cpu_model cpu (.sys_clk(sys_clk), .ioSelect(ioSelect), .readNotWrite(readNotWrite),
        .addressLines(addressLines), .dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut),
        .dataLinesOe(dataLinesOe));
    // clock
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // hang guard: longest test is about 3400 cycles
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errCount++;
            reportAndStop();
        end
    end
    //--------------------------------------------
    // compare, model and closing tasks
    //--------------------------------------------
    task automatic chk(input logic [7:0] act, input logic [7:0] exp);
        checksDone++;
        if (act !== exp)
        begin
            errCount++;
            $display("ERROR t=%0t got %h want %h", $time, act, exp);
        end
    endtask
    // port read: stored bit where output, pin level where input
    function automatic logic [7:0] expRd(input int p);
        logic [7:0] d;
        d = dirM[p][7:0];
        return (outM[p][7:0] & d) | ((p ? extB : extA) & ~d);
    endfunction
    task automatic rdChk(input logic [3:0] addr, input logic [7:0] exp);
        cpu.busRead(addr, rd, oe);
        chk({7'h00, oe}, 8'h01);
        chk(rd, exp);
    endtask
    task automatic reportAndStop();
        $display("checks %0d mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    //--------------------------------------------
    // main sequence
    //--------------------------------------------
    initial
    begin
        v1 = $urandom(64288);
        reset = 1'b1;
        extA = 8'($urandom);
        extB = 8'($urandom);
        repeat (8) @(negedge sys_clk);
        chk({7'h00, dataLinesOe}, 8'h00);
        chk(aOe | bOe, 8'h00);
        repeat (8) @(negedge sys_clk);
        reset = 1'b0; // held well over one period
        // ports: random direction, data and pins per port
        for (int p = 0; p < 2; p++)
        begin
            dirM[p] = 0;
            outM[p] = 0;
            repeat (5) @(negedge sys_clk);
            rdChk(4'(2 * p), expRd(p));
            dirM[p] = $urandom % 256;
            outM[p] = $urandom % 256;
            cpu.busWrite(4'(2 * p + 1), 8'(dirM[p]));
            cpu.busWrite(4'(2 * p), 8'(outM[p]));
            chk({7'h00, dataLinesOe}, 8'h00);
            extA = 8'($urandom);
            extB = 8'($urandom);
            repeat (5) @(negedge sys_clk); // pins pass a 3-flop sync
            chk(p ? bOe : aOe, 8'(dirM[p]));
            chk(p ? bOut : aOut, 8'(outM[p]));
            rdChk(4'(2 * p), expRd(p));
            rdChk(4'(2 * p + 1), 8'(dirM[p]));
            chk(p ? bOut : aOut, 8'(outM[p]));
        end
        // second reset mid-run clears every direction register
        reset = 1'b1;
        repeat (2) @(negedge sys_clk);
        reset = 1'b0; // port B top line is left an input
        for (int p = 0; p < 2; p++)
            rdChk(4'(2 * p + 1), 8'h00);
        $display("test ports done");
        // timer: each rate, count of two, interrupt enabled
        for (int r = 0; r < 4; r++)
        begin
            dv = (r == 3) ? 1024 : (1 << (3 * r));
            cpu.busWrite({2'b11, 2'(r)}, 8'h02);
            t0 = cyc;
            // port B outputs are registered, so the enabled pull-up on line 7 shows one clock later
            @(negedge sys_clk);
            chk({6'h00, bOe[7], bOut[7]}, 8'h03);
            if (dv > 1)
            begin
                // read mid-interval, after the first decrement
                repeat (dv + dv / 2 - 1) @(negedge sys_clk);
                rdChk(4'hC, 8'h01);
            end
            while (irqFlag !== 1'b1 && cyc - t0 < 4000)
                @(negedge sys_clk);
            c = cyc - t0;
            chk({7'h00, c >= 2 * dv && c <= 3 * dv + 3}, 8'h01);
            @(negedge sys_clk);
            chk({6'h00, bOe[7], bOut[7]}, 8'h02);
            rdChk(4'hD, 8'h01);
            @(negedge sys_clk); // irqFlag trails the internal flag by one clock
            chk({7'h00, irqFlag}, 8'h00);
            // A3 low on reads after an interrupt
            cpu.busRead(4'h4, rd, oe);
            v1 = rd;
            chk({7'h00, rd >= 8'hE0}, 8'h01);
            repeat (9) @(negedge sys_clk);
            rdChk(4'h4, 8'(v1 - 11));
            chk({7'h00, bOe[7]}, 8'h00);
        end
        $display("test timer rates done");
        // count after interrupt stops at minus 255
        cpu.busWrite(4'h4, 8'h00);
        repeat (300) @(negedge sys_clk);
        rdChk(4'h4, 8'h01);
        $display("test timer floor done");
        reportAndStop();
    end
endmodule
